// ### rtl/ppi_engine.sv
// programmable parallel interface engine with register port
// assumes ctl_in and data_in are asynchronous pins, buffer side on clk
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module ppi_engine #(
  parameter int DATA_W = 32,
  parameter int CTL_N  = 16,
  parameter int NBUF   = 32
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [15:0] ctl_in,
  output logic      [15:0] ctl_out,
  output logic      [15:0] ctl_oe,
  input  wire logic [31:0] data_in,
  output logic      [31:0] data_out,
  output logic      [31:0] data_oe,
  output logic             if_clk_out,
  output logic             if_clk_oe,
  output logic             int_n_out,
  output logic      [4:0]  buf_idx,
  output logic             buf_wr_valid,
  output logic      [31:0] buf_wr_data,
  output logic             buf_rd_req,
  input  wire logic [31:0] buf_rd_data,
  input  wire logic [31:0] buf_ready,
  output logic             irq
);
  // ==========================================================
  // elaboration checks
  if (DATA_W != 32 || CTL_N != 16 || NBUF != 32) begin : g_bad
    $error("ppi_engine supports only 32 data, 16 pins, 32 buffers");
  end

  // ==========================================================
  // reset release
  logic rst_meta_ff;
  logic rstn_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rstn_ff     <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rstn_ff     <= rst_meta_ff;
    end
  end

  // ==========================================================
  // declarations
  logic [31:0] ctrl_ff;
  logic [31:0] pin_dir_ff;
  logic [7:0]  start_ff;
  logic [1:0]  irq_stat_ff;
  logic [1:0]  irq_mask_ff;
  logic [10:0] desc_addr_ff;
  logic [15:0] def_out_ff;
  logic        running_ff;
  logic [7:0]  state_ff;
  logic [7:0]  nxt_state;
  logic [63:0] word;
  logic [9:0]  mem_raddr;
  logic        desc_we;
  logic        go;
  logic        halt_ev;
  logic        cpu_ev;
  logic        cond;
  logic [15:0] ctl_sync;
  logic [31:0] data_meta_ff;
  logic [31:0] data_sync_ff;
  logic [31:0] width_mask;
  logic [15:0] pin_val;
  logic [15:0] pin_oe_req;
  logic [4:0]  sel;
  logic [4:0]  nxt_buf_idx;
  logic [1:0]  bus_width;
  logic [1:0]  bank;
  logic [3:0]  flag_pin;

  assign bus_width = ctrl_ff[ppi_pkg::CTRL_WIDTH +: 2];
  assign bank      = ctrl_ff[ppi_pkg::CTRL_BANK +: 2];
  assign flag_pin  = ctrl_ff[ppi_pkg::CTRL_FLAG_PIN +: 4];

  // ==========================================================
  // register writes
  assign desc_we = reg_wr && (reg_addr == ppi_pkg::OFS_DESC_DATA);

  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      ctrl_ff <= ppi_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == ppi_pkg::OFS_CTRL) begin
      ctrl_ff <= reg_wdata;
    end else begin
      if (desc_we) begin
        ctrl_ff[ppi_pkg::CTRL_LOADED] <= 1'b0;
      end
      if (halt_ev) begin
        ctrl_ff[ppi_pkg::CTRL_RUN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      pin_dir_ff  <= 32'h0;
      start_ff    <= 8'h0;
      irq_mask_ff <= 2'h0;
      def_out_ff  <= 16'h0;
    end else if (reg_wr) begin
      if (reg_addr == ppi_pkg::OFS_PIN_DIR) begin
        pin_dir_ff <= reg_wdata;
      end
      if (reg_addr == ppi_pkg::OFS_START) begin
        start_ff <= reg_wdata[7:0];
      end
      if (reg_addr == ppi_pkg::OFS_IRQ_MASK) begin
        irq_mask_ff <= reg_wdata[1:0];
      end
      if (reg_addr == ppi_pkg::OFS_DEF_OUT) begin
        def_out_ff <= reg_wdata[15:0];
      end
    end
  end

  // descriptor pointer auto-increments per data write
  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      desc_addr_ff <= 11'h0;
    end else if (reg_wr && reg_addr == ppi_pkg::OFS_DESC_ADDR) begin
      desc_addr_ff <= reg_wdata[10:0];
    end else if (desc_we) begin
      desc_addr_ff <= desc_addr_ff + 11'h1;
    end
  end

  // ==========================================================
  // register reads and interrupts
  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ppi_pkg::OFS_CTRL:      reg_rdata <= ctrl_ff;
        ppi_pkg::OFS_STATUS:    reg_rdata <= {16'h0, state_ff,
                                              7'h0, running_ff};
        ppi_pkg::OFS_PIN_DIR:   reg_rdata <= pin_dir_ff;
        ppi_pkg::OFS_START:     reg_rdata <= {24'h0, start_ff};
        ppi_pkg::OFS_IRQ_STAT:  reg_rdata <= {30'h0, irq_stat_ff};
        ppi_pkg::OFS_IRQ_MASK:  reg_rdata <= {30'h0, irq_mask_ff};
        ppi_pkg::OFS_DESC_ADDR: reg_rdata <= {21'h0, desc_addr_ff};
        ppi_pkg::OFS_DEF_OUT:   reg_rdata <= {16'h0, def_out_ff};
        default:                reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // read clears, a new event in the same cycle survives
  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      irq_stat_ff <= 2'h0;
    end else begin
      irq_stat_ff <= ((reg_rd && reg_addr == ppi_pkg::OFS_IRQ_STAT) ?
                      2'h0 : irq_stat_ff) | {cpu_ev, halt_ev};
    end
  end

  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ==========================================================
  // waveform memory
  assign mem_raddr = {bank,
                      running_ff ? nxt_state : start_ff};

  wave_mem #(.AW(10)) u_mem (
    .clk   (clk),
    .rstn  (rstn_ff),
    .we    (desc_we),
    .waddr (desc_addr_ff),
    .wdata (reg_wdata),
    .raddr (mem_raddr),
    .rdata (word)
  );

  // ==========================================================
  // state sequencer
  assign go = ctrl_ff[ppi_pkg::CTRL_RUN] &&
              ctrl_ff[ppi_pkg::CTRL_LOADED] && !running_ff;
  assign halt_ev = running_ff && word[ppi_pkg::SW_HALT];
  assign cpu_ev  = running_ff && word[ppi_pkg::SW_EVT];
  assign sel     = word[ppi_pkg::SW_SEL +: 5];

  always_comb begin
    if (sel < ppi_pkg::SEL_FLAG) begin
      cond = ctl_sync[sel[3:0]];
    end else if (sel == ppi_pkg::SEL_FLAG) begin
      cond = buf_ready[buf_idx];
    end else begin
      cond = 1'b1;
    end
    nxt_state = (cond == word[ppi_pkg::SW_POL]) ?
                word[ppi_pkg::SW_NTRUE +: 8] :
                word[ppi_pkg::SW_NFALSE +: 8];
  end

  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      running_ff <= 1'b0;
      state_ff   <= 8'h0;
    end else if (go) begin
      running_ff <= 1'b1;
      state_ff   <= start_ff;
    end else if (running_ff) begin
      running_ff <= ctrl_ff[ppi_pkg::CTRL_RUN] && !halt_ev;
      state_ff   <= nxt_state;
    end
  end

  // ==========================================================
  // control pins
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_val[i]    = running_ff ? word[ppi_pkg::SW_OUT + i] :
                      def_out_ff[i];
      pin_oe_req[i] = running_ff && word[ppi_pkg::SW_OE + i];
    end
    if (ctrl_ff[ppi_pkg::CTRL_FLAG_EN]) begin
      pin_val[flag_pin] = buf_ready[buf_idx];
    end
  end

  for (genvar g = 0; g < 16; g++) begin : g_pin
    ctl_pin u_pin (
      .clk      (clk),
      .rstn     (rstn_ff),
      .dir      (pin_dir_ff[2*g +: 2]),
      .usable   ((g < ppi_pkg::PINS_AT_32) ||
                 (bus_width != ppi_pkg::WIDTH_32)),
      .out_val  (pin_val[g]),
      .oe_req   (pin_oe_req[g]),
      .pin_in   (ctl_in[g]),
      .pin_out  (ctl_out[g]),
      .pin_oe   (ctl_oe[g]),
      .pin_sync (ctl_sync[g])
    );
  end

  // ==========================================================
  // data bus
  always_comb begin
    unique case (bus_width)
      ppi_pkg::WIDTH_8:  width_mask = 32'h0000_00FF;
      ppi_pkg::WIDTH_16: width_mask = 32'h0000_FFFF;
      ppi_pkg::WIDTH_24: width_mask = 32'h00FF_FFFF;
      ppi_pkg::WIDTH_32: width_mask = 32'hFFFF_FFFF;
    endcase
  end

  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      data_meta_ff <= 32'h0;
      data_sync_ff <= 32'h0;
    end else begin
      data_meta_ff <= data_in;
      data_sync_ff <= data_meta_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      data_out <= 32'h0;
      data_oe  <= 32'h0;
    end else if (running_ff) begin
      data_oe <= word[ppi_pkg::SW_DRV] ? width_mask : 32'h0;
      if (word[ppi_pkg::SW_LOAD]) begin
        data_out <= buf_rd_data & width_mask;
      end else if (word[ppi_pkg::SW_SHIFT]) begin
        data_out <= {data_out[30:0], data_sync_ff[0]} &
                    width_mask;
      end
    end else begin
      data_oe <= 32'h0;
    end
  end

  // ==========================================================
  // buffer side
  assign nxt_buf_idx = ctrl_ff[ppi_pkg::CTRL_ALLBUF] ? ctl_sync[4:0] :
                       {3'h0, ctl_sync[1:0]};

  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      buf_idx      <= 5'h0;
      buf_wr_valid <= 1'b0;
      buf_wr_data  <= 32'h0;
      buf_rd_req   <= 1'b0;
    end else begin
      buf_idx      <= nxt_buf_idx;
      buf_wr_valid <= running_ff && word[ppi_pkg::SW_CAP];
      buf_wr_data  <= data_sync_ff & width_mask;
      buf_rd_req   <= running_ff && word[ppi_pkg::SW_LOAD];
    end
  end

  // ==========================================================
  // interrupt pin and master clock
  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      int_n_out <= 1'b1;
    end else begin
      int_n_out <= !(running_ff && word[ppi_pkg::SW_INT]);
    end
  end

  // master clock toggles per state, half the core rate
  always_ff @(posedge clk or negedge rstn_ff) begin
    if (!rstn_ff) begin
      if_clk_out <= 1'b0;
      if_clk_oe  <= 1'b0;
    end else begin
      if_clk_oe  <= ctrl_ff[ppi_pkg::CTRL_MASTER];
      if_clk_out <= running_ff && ctrl_ff[ppi_pkg::CTRL_MASTER] &&
                    !if_clk_out;
    end
  end
endmodule

// ### rtl/ppi_pkg.sv
// constants, register map and descriptor layout of the parallel engine
// assumes a single 100 MHz clock and a plain one-cycle register port
//
// Functional notes
// - engine runs as bus master or slave
// - 256 firmware programmable engine states
// - data bus 8, 16, 24 or 32 bits
// - interface rate at most 100 MHz
// - 14 control pins with 32-bit bus
// - 16 control pins with 8/16-bit bus
// - each pin input, output or bidirectional
// - next state from state and sampled inputs
// - control outputs follow taken transitions
// - interrupt pin driven by state machine
// - loaded descriptor defines the state machine behaviour
// - descriptor in dedicated 8 KB waveform memory
// - parallel or serial protocols per descriptor
// - one bus word per cycle sustained
// - external party selects one of four buffers
// - optional access to all 32 buffers
// - buffer status flags routable to outputs
package ppi_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ      = 100;
  localparam int IF_MAX_MHZ   = 100;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_PIN_DIR   = 8'h08;
  localparam logic [7:0] OFS_START     = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;
  localparam logic [7:0] OFS_DESC_ADDR = 8'h18;
  localparam logic [7:0] OFS_DESC_DATA = 8'h1C;
  localparam logic [7:0] OFS_DEF_OUT   = 8'h20;
  // ==========================================================
  // control register fields
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_MASTER  = 1;
  localparam int CTRL_WIDTH   = 2;
  localparam int CTRL_ALLBUF  = 4;
  localparam int CTRL_BANK    = 5;
  localparam int CTRL_LOADED  = 7;
  localparam int CTRL_FLAG_EN = 8;
  localparam int CTRL_FLAG_PIN = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_24 = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h3;
  localparam logic [1:0] DIR_IN   = 2'h0;
  localparam logic [1:0] DIR_OUT  = 2'h1;
  localparam logic [1:0] DIR_BIDI = 2'h2;
  // ==========================================================
  // interrupt status bits
  localparam int IRQ_HALT  = 0;
  localparam int IRQ_EVENT = 1;
  // ==========================================================
  // state word layout, 64 bits per state
  localparam int SW_OUT   = 0;
  localparam int SW_OE    = 16;
  localparam int SW_INT   = 32;
  localparam int SW_DRV   = 33;
  localparam int SW_CAP   = 34;
  localparam int SW_SHIFT = 35;
  localparam int SW_EVT   = 36;
  localparam int SW_HALT  = 37;
  localparam int SW_LOAD  = 38;
  localparam int SW_SEL   = 39;
  localparam int SW_POL   = 44;
  localparam int SW_NTRUE = 45;
  localparam int SW_NFALSE = 53;
  localparam logic [4:0] SEL_FLAG   = 5'h10;
  localparam int PINS_AT_32 = 14;
  typedef enum logic [1:0] {IDLE_T_UNUSED} spare_t;
endpackage

// ### rtl/wave_mem.sv
// 8 KB waveform memory, 32-bit write port, 64-bit registered read
// assumes writes and reads in the core clock domain
`timescale 1ns/1ns
module wave_mem #(
  parameter int AW = 10
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          we,
  input  wire logic [AW:0]   waddr,
  input  wire logic [31:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [63:0]   rdata
);
  // ==========================================================
  // storage, two halves of each state word
  logic [31:0] lo_mem [0:(1<<AW)-1];
  logic [31:0] hi_mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we && !waddr[0]) begin
      lo_mem[waddr[AW:1]] <= wdata;
    end
    if (we && waddr[0]) begin
      hi_mem[waddr[AW:1]] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 64'h0;
    end else begin
      rdata <= {hi_mem[raddr], lo_mem[raddr]};
    end
  end
endmodule

// ### rtl/ctl_pin.sv
// one configurable control pin: input, output or bidirectional
// assumes pin_in is asynchronous to clk
`timescale 1ns/1ns
module ctl_pin (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [1:0] dir,
  input  wire logic       usable,
  input  wire logic       out_val,
  input  wire logic       oe_req,
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe,
  output logic            pin_sync
);
  logic meta_ff;

  // ==========================================================
  // input synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff  <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta_ff  <= pin_in;
      pin_sync <= meta_ff;
    end
  end

  // ==========================================================
  // output drive by direction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= out_val;
      pin_oe  <= usable && ((dir == ppi_pkg::DIR_OUT) ||
                 ((dir == ppi_pkg::DIR_BIDI) && oe_req));
    end
  end
endmodule

// ### tb/ppi_engine_sva.sv
// checker for the parallel engine port behaviour
// assumes one clock domain, bound to ppi_engine
`timescale 1ns/1ns
module ppi_engine_chk (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] ctl_oe,
  input wire logic [31:0] data_oe,
  input wire logic        if_clk_oe,
  input wire logic        int_n_out,
  input wire logic        buf_wr_valid,
  input wire logic        buf_rd_req,
  input wire logic        irq
);
  // ==========================================================
  // shadow of software settings
  logic [1:0] mask_ff;
  logic [1:0] width_ff;
  logic       master_ff;
  logic       armed_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      width_ff  <= 2'h0;
      master_ff <= 1'b0;
      armed_ff  <= 1'b0;
    end else if (reg_wr && reg_addr == ppi_pkg::OFS_CTRL) begin
      width_ff  <= reg_wdata[3:2];
      master_ff <= reg_wdata[1];
      armed_ff  <= armed_ff | reg_wdata[0];
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_ff <= 2'h0;
    end else if (reg_wr && reg_addr == ppi_pkg::OFS_IRQ_MASK) begin
      mask_ff <= reg_wdata[1:0];
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rd_quiet;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data outside its slot");
  property p_unmapped;
    reg_rd && reg_addr > ppi_pkg::OFS_DEF_OUT |=> reg_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_desc_rd;
    reg_rd && reg_addr == ppi_pkg::OFS_DESC_DATA |=> reg_rdata == 32'h0;
  endproperty
  a_desc_rd: assert property (p_desc_rd)
    else $error("waveform data port readable");
  property p_mask_rb;
    reg_rd && reg_addr == ppi_pkg::OFS_IRQ_MASK
      |=> reg_rdata[1:0] == $past(mask_ff);
  endproperty
  a_mask_rb: assert property (p_mask_rb)
    else $error("mask readback wrong");
  property p_irq_mask;
    (mask_ff == 2'h0)[*3] |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq while all masked");
  property p_reset_idle;
    $rose(resetn) |-> int_n_out && ctl_oe == 16'h0 && data_oe == 32'h0;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("pins active at reset release");
  property p_idle;
    !armed_ff |-> !buf_wr_valid && !buf_rd_req;
  endproperty
  a_idle: assert property (p_idle)
    else $error("buffer traffic before start");
  property p_pins32;
    (width_ff == ppi_pkg::WIDTH_32)[*3] |-> ctl_oe[15:14] == 2'h0;
  endproperty
  a_pins32: assert property (p_pins32)
    else $error("upper pins driven at full width");
  property p_master;
    $stable(master_ff)[*3] |-> if_clk_oe == master_ff;
  endproperty
  a_master: assert property (p_master)
    else $error("clock pin enable not following role");
endmodule

// ### tb/ext_bus_party.sv
// model of the external party on the parallel bus
// assumes the engine samples its pins through synchronisers
`timescale 1ns/1ns
module ext_bus_party (
  input wire logic        clk,
  input wire logic [1:0]  sel,
  input wire logic [31:0] word,
  input wire logic [15:0] ctl_out,
  input wire logic [15:0] ctl_oe,
  input wire logic [31:0] data_out,
  input wire logic [31:0] data_oe,
  output logic     [15:0] ctl_in,
  output logic     [31:0] data_in
);
  initial begin
    ctl_in  = 16'h0000;
    data_in = 32'h0000_0000;
  end
  // ==========================================================
  // wire levels, undriven control pins 15:2 toggle every cycle, undriven data pins take word
  always @(posedge clk) begin
    // full 32-bit word at core rate
    data_in <= (data_oe & data_out) | (~data_oe & word);
    // buffer select on pins 1:0
    ctl_in  <= (ctl_oe & ctl_out) | (~ctl_oe & {~ctl_in[15:2], sel});
  end
endmodule

// ### tb/programmable_parallel_interface_bench.sv
// self-checking bench for the parallel engine
// assumes ppi_engine, ext_bus_party and ppi_engine_chk compiled first
`timescale 1ns/1ns
module programmable_parallel_interface_bench;
  logic        clk, resetn, reg_wr, reg_rd, int_n_out, if_clk_oe;
  logic        buf_wr_valid, buf_rd_req, irq, if_clk_out;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, data_in, data_out, data_oe;
  logic [15:0] ctl_in, ctl_out, ctl_oe, pat;
  logic [4:0]  buf_idx;
  logic [31:0] buf_wr_data, buf_rd_data, buf_ready, word, rd_val, d, wm;
  logic [1:0]  sel;
  logic [63:0] sw;
  int          err_count, num_checks, n_cap;
  integer      seed;

  ppi_engine i_ppi_engine (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ctl_in(ctl_in), .ctl_out(ctl_out),
    .ctl_oe(ctl_oe), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .if_clk_out(if_clk_out), .if_clk_oe(if_clk_oe),
    .int_n_out(int_n_out), .buf_idx(buf_idx), .buf_wr_valid(buf_wr_valid),
    .buf_wr_data(buf_wr_data), .buf_rd_req(buf_rd_req),
    .buf_rd_data(buf_rd_data), .buf_ready(buf_ready), .irq(irq));
  ext_bus_party i_ext_bus_party (.clk(clk), .sel(sel), .word(word),
    .ctl_out(ctl_out), .ctl_oe(ctl_oe), .data_out(data_out),
    .data_oe(data_oe), .ctl_in(ctl_in), .data_in(data_in));

  initial clk = 1'b0;
  always #5 clk = ~clk;
  // ==========================================================
  // helpers
  task automatic chk(input string n, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input string n,
                    input logic [31:0] e, m);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk(n, rd_val & m, e);
  endtask
  function automatic logic [63:0] sword(input logic last);
    sword = 64'h0;
    sword[ppi_pkg::SW_OUT +: 16] = last ? ~pat : pat;
    sword[ppi_pkg::SW_INT] = !last;
    sword[ppi_pkg::SW_LOAD] = !last;
    sword[ppi_pkg::SW_CAP] = 1'b1;
    sword[ppi_pkg::SW_EVT] = last;
    sword[ppi_pkg::SW_HALT] = last;
    sword[ppi_pkg::SW_SEL +: 5] = 5'h11;
    sword[ppi_pkg::SW_POL] = 1'b1;
    sword[ppi_pkg::SW_NTRUE +: 8] = 8'h01;
    sword[ppi_pkg::SW_NFALSE +: 8] = 8'h01;
  endfunction
  function automatic logic [31:0] pins(input int n);
    pins = {16'h0, (n == 1) ? pat : ~pat};
  endfunction
  function automatic logic [31:0] oes(input logic full);
    oes = full ? 32'h0000_3FF0 : 32'h0000_FFF0;
  endfunction
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // captured words
  always @(posedge clk) begin
    if (buf_wr_valid === 1'b1) begin
      n_cap++;
      chk("buf_wr_data", buf_wr_data, word & wm);
      chk("buf_idx", {27'h0, buf_idx}, {30'h0, sel});
      chk("int_n_out", {31'h0, int_n_out}, 32'(n_cap > 1));
      chk("ctl_out", {16'h0, ctl_out}, pins(n_cap));
      chk("ctl_oe", {16'h0, ctl_oe}, oes(wm[31]));
      chk("buf_rd_req", {31'h0, buf_rd_req}, 32'(n_cap == 1));
      chk("data_out", data_out, buf_rd_data & wm);
      chk("if_clk_out", {31'h0, if_clk_out}, 32'(n_cap == 1));
    end
  end
  initial begin
    #100000;
    err_count++;
    conclude;
  end
  // ==========================================================
  // tests
  initial begin
    seed = 73837;
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {buf_rd_data, word, sel, n_cap, err_count, num_checks} = '0;
    {pat, wm} = '0;
    buf_ready = 32'hFFFF_FFFF;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rc(ppi_pkg::OFS_CTRL, "ctrl", ppi_pkg::CTRL_RESET, '1);
    rc(8'h40, "unmapped", 32'h0, '1);
    wr(ppi_pkg::OFS_DESC_DATA, 32'hFFFF_FFFF);
    rc(ppi_pkg::OFS_DESC_DATA, "desc data", 32'h0, '1);
    $display("test reset values done");
    for (int w = 0; w < 4; w++) begin
      d = 32'((w << 2) | ((w & 1) << 1));
      wr(ppi_pkg::OFS_CTRL, d);
      rc(ppi_pkg::OFS_CTRL, "width", d, 32'hF);
      repeat (3) @(posedge clk);
      chk("clk oe", {31'h0, if_clk_oe}, 32'(w & 1));
    end
    wr(ppi_pkg::OFS_CTRL, 32'h0000_000D);
    rc(ppi_pkg::OFS_STATUS, "run unloaded", 32'h0, 32'h1);
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      wr(ppi_pkg::OFS_IRQ_MASK, d);
      rc(ppi_pkg::OFS_IRQ_MASK, "mask", d & 32'h3, 32'h3);
    end
    $display("test config done");
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      sel <= 2'($random(seed));
      pat <= 16'($random(seed));
      word <= $random(seed);
      buf_rd_data <= $random(seed);
      wm <= r ? 32'h0000_FFFF : 32'hFFFF_FFFF;
      wr(ppi_pkg::OFS_IRQ_MASK, 32'h1);
      wr(ppi_pkg::OFS_PIN_DIR, 32'h5555_5500);
      wr(ppi_pkg::OFS_START, 32'h0);
      wr(ppi_pkg::OFS_DESC_ADDR, 32'h0);
      for (int s = 0; s < 2; s++) begin
        sw = sword(s[0]);
        wr(ppi_pkg::OFS_DESC_DATA, sw[31:0]);
        wr(ppi_pkg::OFS_DESC_DATA, sw[63:32]);
      end
      n_cap = 0;
      wr(ppi_pkg::OFS_CTRL, r ? 32'h0000_0087 : 32'h0000_008F);
      for (int i = 0; i < 50 && irq !== 1'b1; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk("halt irq", {31'h0, irq}, 32'h1);
      chk("captures", 32'(n_cap), 32'h2);
      rc(ppi_pkg::OFS_STATUS, "halted", 32'h0, 32'h1);
      rc(ppi_pkg::OFS_CTRL, "run cleared", 32'h0, 32'h1);
      rc(ppi_pkg::OFS_IRQ_STAT, "stat", 32'h3, 32'h3);
      rc(ppi_pkg::OFS_IRQ_STAT, "stat clear", 32'h0, 32'h3);
      repeat (3) @(posedge clk);
      chk("irq clear", {31'h0, irq}, 32'h0);
      $display("test run %0d done", r);
    end
    conclude;
  end
endmodule

bind ppi_engine ppi_engine_chk i_ppi_engine_chk (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctl_oe(ctl_oe),
  .data_oe(data_oe), .if_clk_oe(if_clk_oe), .int_n_out(int_n_out),
  .buf_wr_valid(buf_wr_valid), .buf_rd_req(buf_rd_req), .irq(irq));
